// file: hw/scc_core.sv
// System control coprocessor: privileged registers, timer, debug mode, TAP.
// Assumes the pipeline presents exception and instruction strobes on aclk.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module scc_core
  import scc_pkg::*;
#(
  parameter int         PERF_W     = 32,
  parameter logic [31:0] IDENTITY  = 32'h00c0ffee  // Arbitrary value
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire scc_exc_t    exc_in,
  input  wire scc_parity_t parity_in,
  input  wire logic        debug_return_instr,
  input  wire logic        wait_instr,
  input  wire logic        wake,
  input  wire logic [1:0]  perf_events,
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             debug_mode,
  output logic             sleep_req,
  output logic             idle_req,
  output logic             parity_en,
  output logic             irq
);
  typedef struct packed {
    logic              aw_got, w_got, bvalid, rvalid;
    logic [4:0]        aw_idx;
    logic [31:0]       wdata;
    logic [31:0]       rdata;
    logic [1:0]        bresp, rresp;
    logic [31:0]       user_w, hw_mask, fault_a, tally, match, status, reason;
    logic [31:0]       exc_pc, dbg_ctl, dbg_pc, parity_ctl, parity_log, err_pc, dsave;
    logic [31:0]       hw_rd_req;
    logic [1:0][31:0]  perf_ctl;
    logic [1:0][PERF_W-1:0] perf_cnt;
    logic [IRQ_N-1:0]  irq_st, irq_en;
    logic              debug, sleep, idle, irq;
    logic [2:0]        tck_s, tms_s, tdi_s;
    scc_tap_state_t    tap;
    logic [3:0]        ir;
    logic [31:0]       dr;
    logic              tdo;
    logic              awrdy, wrdy, arrdy, dr_scan;
  } scc_state_t;

  scc_state_t q, d;
  logic [4:0]       ar_idx, wr_idx;
  logic [31:0]      rd_val;
  logic             rd_ok, wr_ok, wr_fire, tck_rise, tck_fall, user_ok;
  logic [IRQ_N-1:0] ev;

  // Read mux; reserved numbers read as zero
  always_comb begin
    ar_idx = s_axi_araddr[6:2];
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    case (ar_idx)
      REG_USER_SCRATCH:  rd_val = q.user_w;
      REG_HW_READ_MASK:  rd_val = q.hw_mask;
      REG_FAULT_ADDR:    rd_val = q.fault_a;
      REG_CYCLE_TALLY:   rd_val = q.tally;
      REG_TIMER_MATCH:   rd_val = q.match;
      REG_STATUS_CTL:    rd_val = q.status;
      REG_EXC_REASON:    rd_val = q.reason;
      REG_EXC_RET_PC:    rd_val = q.exc_pc;
      REG_PROC_IDENTITY: rd_val = IDENTITY;
      REG_CORE_CONFIG:   rd_val = CONFIG_RESET;
      REG_DEBUG_CTL:     rd_val = {q.dbg_ctl[31], q.debug, q.dbg_ctl[29:0]};
      REG_DEBUG_RET_PC:  rd_val = q.dbg_pc;
      REG_PERF:          rd_val = q.perf_ctl[0];                // see RULE11
      REG_PERF_TALLY0:   rd_val = 32'(q.perf_cnt[0]);
      REG_PERF_CTL1:     rd_val = q.perf_ctl[1];
      REG_PERF_TALLY1:   rd_val = 32'(q.perf_cnt[1]);
      REG_PARITY_CTL:    rd_val = q.parity_ctl;
      REG_PARITY_LOG:    rd_val = q.parity_log;                 // see RULE9
      REG_ERR_RET_PC:    rd_val = q.err_pc;
      REG_DEBUG_SCRATCH: rd_val = q.dsave;                      // see RULE8
      REG_IRQ_STATUS:    rd_val = 32'(q.irq_st);
      REG_IRQ_ENABLE:    rd_val = 32'(q.irq_en);
      // User-visible hardware register read, gated by the mask
      REG_HW_READ_REQ:   rd_val = user_ok ? q.user_w : 32'h0;   // see RULE1
      default:           rd_ok = 1'b0;                          // see RULE19
    endcase
  end

  // Index 29 passes in user mode only when its mask bit is set
  assign user_ok = (q.hw_rd_req[4:0] == HWR_USER_INDEX) &&
                   (!q.status[STATUS_USER_BIT] || q.hw_mask[HWR_USER_INDEX]); // see RULE2

  always_comb begin
    d = q;
    wr_idx  = q.aw_idx;
    ev      = '0;
    // Write address and data taken in either order
    if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
      d.aw_got = 1'b1;
      d.aw_idx = s_axi_awaddr[6:2];
      wr_idx   = s_axi_awaddr[6:2];
    end
    if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
    end
    wr_fire = d.aw_got && d.w_got && !q.bvalid;
    wr_ok   = 1'b1;
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_val;
      d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Timer advances every cycle; counters only on their enabled events
    d.tally = q.tally + 32'h1;                                  // see RULE18
    if (q.tally == q.match) ev[IRQ_TIMER] = 1'b1;               // see RULE18
    for (int i = 0; i < 2; i++) begin
      if (q.perf_ctl[i][PERF_EN_BIT] && perf_events[i]) begin
        d.perf_cnt[i] = q.perf_cnt[i] + PERF_W'(1);
        if (&q.perf_cnt[i]) ev[IRQ_PERF0 + i] = 1'b1;
      end
    end

    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      case (wr_idx)
        REG_USER_SCRATCH:  d.user_w = d.wdata;                  // see RULE1
        REG_HW_READ_MASK:  d.hw_mask = d.wdata;                 // see RULE2
        REG_CYCLE_TALLY:   d.tally = d.wdata;
        REG_TIMER_MATCH: begin
          d.match = d.wdata;
          d.irq_st[IRQ_TIMER] = 1'b0;                           // see RULE18
        end
        REG_STATUS_CTL:    d.status = d.wdata;
        REG_EXC_REASON:    d.reason = d.wdata;
        REG_EXC_RET_PC:    d.exc_pc = d.wdata;
        REG_DEBUG_CTL:     d.dbg_ctl = d.wdata;
        REG_DEBUG_RET_PC:  d.dbg_pc = d.wdata;
        REG_PERF:          d.perf_ctl[0] = d.wdata;             // see RULE11
        REG_PERF_TALLY0:   d.perf_cnt[0] = d.wdata[PERF_W-1:0];
        REG_PERF_CTL1:     d.perf_ctl[1] = d.wdata;
        REG_PERF_TALLY1:   d.perf_cnt[1] = d.wdata[PERF_W-1:0];
        REG_PARITY_CTL:    d.parity_ctl = d.wdata;              // see RULE10
        REG_ERR_RET_PC:    d.err_pc = d.wdata;
        REG_DEBUG_SCRATCH: d.dsave = d.wdata;                   // see RULE8
        REG_IRQ_CLEAR:     d.irq_st = q.irq_st & ~d.wdata[IRQ_N-1:0];
        REG_IRQ_ENABLE:    d.irq_en = d.wdata[IRQ_N-1:0];
        REG_HW_READ_REQ:   d.hw_rd_req = d.wdata;
        default:           wr_ok = 1'b0;                        // see RULE19
      endcase
      d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Exception capture
    if (exc_in.valid) begin
      ev[IRQ_EXC] = 1'b1;
      d.reason = {q.reason[31:7], exc_in.code, 2'b00};          // see RULE4
      if (exc_in.addr_err) d.fault_a = exc_in.addr;             // see RULE3
      if (exc_in.debug) begin
        d.dbg_pc = exc_in.pc;                                   // see RULE6
        d.debug = 1'b1;                                         // see RULE15
        ev[IRQ_DEBUG] = 1'b1;
      end else if (exc_in.error_class) begin
        d.err_pc = exc_in.pc;                                   // see RULE7
      end else begin
        d.exc_pc = exc_in.pc;                                   // see RULE5
      end
    end else if (debug_return_instr) begin
      d.debug = 1'b0;                                           // see RULE16
    end

    // Parity log only while checking is enabled
    if (parity_in.valid && q.parity_ctl[PARITY_EN_BIT]) begin
      d.parity_log = parity_in.info;                            // see RULE9
      ev[IRQ_PARITY] = 1'b1;
    end

    // Power-down: registers simply hold while stopped, see RULE13 and RULE14
    if (wait_instr) begin                                       // see RULE12
      d.sleep = q.status[STATUS_SLEEP_BIT];
      d.idle  = !q.status[STATUS_SLEEP_BIT];
    end else if (wake || exc_in.valid) begin
      d.sleep = 1'b0;
      d.idle  = 1'b0;
    end

    // Set wins over clear
    d.irq_st = d.irq_st | ev;
    d.irq    = |(d.irq_st & d.irq_en);

    // Ready flags kept in flops for the bus outputs
    d.awrdy = !d.aw_got && !d.bvalid;
    d.wrdy  = !d.w_got && !d.bvalid;
    d.arrdy = !d.rvalid;

    // Test access port, sampled on aclk
    d.tck_s = {q.tck_s[1:0], tck};
    d.tms_s = {q.tms_s[1:0], tms};
    d.tdi_s = {q.tdi_s[1:0], tdi};
    tck_rise = q.tck_s[1] && !q.tck_s[2];
    tck_fall = !q.tck_s[1] && q.tck_s[2];
    if (tck_rise) begin                                         // see RULE17
      case (q.tap)
        TAP_IDLE: begin
          if (q.tms_s[1]) d.tap = TAP_SHDR;
          d.dr_scan = 1'b0;
          case (q.ir)
            TAP_IR_IDCODE: d.dr = IDENTITY;
            TAP_IR_DATA:   d.dr = q.dsave;
            default:       d.dr = 32'h0;
          endcase
        end
        TAP_SHDR: begin
          if (q.tms_s[1]) d.tap = TAP_SHIR;
          else if (q.ir == TAP_IR_BYPASS) d.dr = {31'h0, q.tdi_s[1]};
          else d.dr = {q.tdi_s[1], q.dr[31:1]};
          if (!q.tms_s[1]) d.dr_scan = 1'b1;
        end
        TAP_SHIR: begin
          if (q.tms_s[1]) d.tap = TAP_UPD;
          else d.ir = {q.tdi_s[1], q.ir[3:1]};
          if (!q.tms_s[1]) d.dr_scan = 1'b0;
        end
        TAP_UPD: begin
          d.tap = TAP_IDLE;
          // Only a data scan may load the scratch word
          if (q.ir == TAP_IR_DATA && q.dr_scan) d.dsave = q.dr;
        end
        default: d.tap = TAP_IDLE;
      endcase
    end
    if (tck_fall) d.tdo = q.dr[0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.tap      <= TAP_IDLE;
      q.ir       <= TAP_IR_BYPASS;
      q.bresp    <= RESP_OKAY;
      q.rresp    <= RESP_OKAY;
      q.awrdy    <= 1'b1;
      q.wrdy     <= 1'b1;
      q.arrdy    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awrdy;
  assign s_axi_wready  = q.wrdy;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arrdy;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign tdo           = q.tdo;
  assign debug_mode    = q.debug;
  assign sleep_req     = q.sleep;
  assign idle_req      = q.idle;
  assign parity_en     = q.parity_ctl[PARITY_EN_BIT];
  assign irq           = q.irq;
endmodule : scc_core

// file: hw/scc_pkg.sv
// Constants, register map and carrier types for the system control coprocessor.
// Assumes one core clock, synchronous active-low reset and an AXI4-Lite master.
// Contract
// RULE1: Register 4 user word, readable via index 29
// RULE2: Register 7 masks user hardware register reads
// RULE3: Address exception captures faulting address, register 8
// RULE4: Every exception records its cause code, register 13
// RULE5: Ordinary exception saves return pc, register 14
// RULE6: Debug exception saves return pc, register 24
// RULE7: Error exception saves pc in register 30
// RULE8: Register 31 plain debug scratch, no side effects
// RULE9: Register 27 logs most recent parity error
// RULE10: Register 26 enables parity checking
// RULE11: Register 25 two counters with event controls
// RULE12: Wait instruction enters sleep or idle power-down
// RULE13: Fully static logic, survives stopped clock
// RULE14: Idle logic holds registers without toggling; the cycle tally here keeps counting while idle_req is set
// RULE15: Debug exception enters debug mode
// RULE16: Debug return instruction leaves debug mode
// RULE17: Serial test access port moves debug data
// RULE18: Cycle tally, match raises timer interrupt
// RULE19: Reserved registers read zero, ignore writes
package scc_pkg;
  localparam logic [4:0] REG_USER_SCRATCH  = 5'h04;
  localparam logic [4:0] REG_HW_READ_MASK  = 5'h07;
  localparam logic [4:0] REG_FAULT_ADDR    = 5'h08;
  localparam logic [4:0] REG_CYCLE_TALLY   = 5'h09;
  localparam logic [4:0] REG_TIMER_MATCH   = 5'h0b;
  localparam logic [4:0] REG_STATUS_CTL    = 5'h0c;
  localparam logic [4:0] REG_EXC_REASON    = 5'h0d;
  localparam logic [4:0] REG_EXC_RET_PC    = 5'h0e;
  localparam logic [4:0] REG_PROC_IDENTITY = 5'h0f;
  localparam logic [4:0] REG_CORE_CONFIG   = 5'h10;
  localparam logic [4:0] REG_DEBUG_CTL     = 5'h17;
  localparam logic [4:0] REG_DEBUG_RET_PC  = 5'h18;
  localparam logic [4:0] REG_PERF          = 5'h19;
  localparam logic [4:0] REG_PARITY_CTL    = 5'h1a;
  localparam logic [4:0] REG_PARITY_LOG    = 5'h1b;
  localparam logic [4:0] REG_ERR_RET_PC    = 5'h1e;
  localparam logic [4:0] REG_DEBUG_SCRATCH = 5'h1f;
  // Extra windows beside register 25 for both counter tallies and the second counter's controls
  localparam logic [4:0] REG_PERF_TALLY0   = 5'h1c;
  localparam logic [4:0] REG_PERF_CTL1     = 5'h1d;
  localparam logic [4:0] REG_PERF_TALLY1   = 5'h14;
  localparam logic [4:0] REG_IRQ_STATUS    = 5'h00;
  localparam logic [4:0] REG_IRQ_CLEAR     = 5'h01;
  localparam logic [4:0] REG_IRQ_ENABLE    = 5'h02;
  localparam logic [4:0] REG_HW_READ_REQ   = 5'h03;
  localparam logic [4:0] HWR_USER_INDEX    = 5'h1d;
  localparam int         PARITY_EN_BIT     = 31;
  localparam int         STATUS_USER_BIT   = 4;
  localparam int         STATUS_SLEEP_BIT  = 0;
  localparam int         PERF_EN_BIT       = 4;
  localparam int         DEBUG_MODE_BIT    = 30;
  localparam int         IRQ_TIMER         = 0;
  localparam int         IRQ_PARITY        = 1;
  localparam int         IRQ_PERF0         = 2;
  localparam int         IRQ_PERF1         = 3;
  localparam int         IRQ_EXC           = 4;
  localparam int         IRQ_DEBUG         = 5;
  localparam int         IRQ_N             = 6;
  localparam logic [31:0] CONFIG_RESET     = 32'ha4012582;
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;
  localparam logic [3:0] TAP_IR_IDCODE     = 4'h1;
  localparam logic [3:0] TAP_IR_DATA       = 4'h8;
  localparam logic [3:0] TAP_IR_BYPASS     = 4'hf;

  typedef enum logic [3:0] {
    TAP_IDLE  = 4'h1,
    TAP_SHDR  = 4'h2,
    TAP_SHIR  = 4'h4,
    TAP_UPD   = 4'h8
  } scc_tap_state_t;

  typedef struct packed {
    logic        valid;
    logic        addr_err;
    logic        error_class;
    logic        debug;
    logic [4:0]  code;
    logic [31:0] pc;
    logic [31:0] addr;
  } scc_exc_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] info;
  } scc_parity_t;

  typedef struct packed {
    logic [31:0] q;
    logic        done;
  } scc_rsp_t;
endpackage : scc_pkg

// file: verif/scc_core_sva.sv
// Port checker for scc_core: bus handshakes, debug mode, power-down.
// Assumes binding to scc_core; watches its ports only.
`timescale 1ns/1ps
module scc_core_sva
  import scc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire scc_exc_t    exc_in,
  input wire logic        debug_return_instr,
  input wire logic        wait_instr,
  input wire logic        wake,
  input wire logic        debug_mode,
  input wire logic        sleep_req,
  input wire logic        idle_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("request taken during response");
  dbg_enter_a: assert property (exc_in.valid && exc_in.debug |=> debug_mode)
    else $error("debug mode not entered");
  dbg_keep_a: assert property (debug_mode && !debug_return_instr |=> debug_mode)
    else $error("debug mode left early");
  dbg_leave_a: assert property (debug_return_instr && !exc_in.valid |=> !debug_mode)
    else $error("debug mode not left");
  wait_go_a: assert property (wait_instr && !wake |=> sleep_req || idle_req)
    else $error("no power-down on wait");
  wake_a: assert property (wake && !wait_instr |=> !sleep_req && !idle_req)
    else $error("power-down kept after wake");
  one_mode_a: assert property (!(sleep_req && idle_req))
    else $error("sleep and idle together");
  cover property (exc_in.valid && exc_in.debug);
  cover property (sleep_req);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule : scc_core_sva

bind scc_core scc_core_sva scc_core_sva_inst (.*);

// file: verif/scc_probe.sv
// Debug probe model: drives the serial test access port.
// Assumes the core samples tck with its own clock; tck rests low between frames.
`timescale 1ns/1ps
module scc_probe
  import scc_pkg::*;
(
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  logic [31:0] got;
  logic [31:0] cap;
  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
  end
  // One link clock period, 64 ns; frames start off the aclk rising edges
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #32 tck = 1'b1;
    got = {tdo, got[31:1]};
    #32 tck = 1'b0;
  endtask : step
  task automatic shift(input logic [31:0] v, input int n);
    for (int k = 0; k < n; k++) step(1'b0, v[k]); // LSB first
  endtask : shift
  task automatic ir(input logic [3:0] v);
    #1.25;
    step(1'b1, ~tdi);
    step(1'b1, ~tdi);
    shift({28'h0, v}, 4);
    step(1'b1, ~tdi);
    step(1'b1, ~tdi);
  endtask : ir
  task automatic dr(input logic [31:0] v);
    #1.25;
    step(1'b1, ~tdi);
    shift(v, 32);
    cap = got;
    step(1'b1, ~tdi);
    step(1'b1, ~tdi);
    step(1'b1, ~tdi);
  endtask : dr
endmodule : scc_probe

// file: verif/test_system_control_coprocessor.sv
// Self-checking bench for scc_core: AXI4-Lite master and pipeline strobes.
// Assumes the checker is bound and scc_probe drives the link pins.
`timescale 1ns/1ps
module test_system_control_coprocessor;
  import scc_pkg::*;
  localparam logic [31:0] IDV = 32'h5a3c0001; // Arbitrary value
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_arvalid, s_axi_rready, debug_return_instr, wait_instr, wake;
  logic        tck, tms, tdi, tdo, debug_mode, sleep_req, idle_req, parity_en, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, perf_events;
  scc_exc_t    exc_in;
  scc_parity_t parity_in;
  logic [1:0]  bq [$];
  logic [65:0] rq [$];
  logic [31:0] lf = 32'h9e14;
  logic [4:0]  rw_l [6] = '{REG_USER_SCRATCH, REG_HW_READ_MASK, REG_EXC_RET_PC,
                            REG_DEBUG_RET_PC, REG_ERR_RET_PC, REG_DEBUG_SCRATCH};
  logic [4:0]  rs_l [4] = '{5'h05, 5'h06, 5'h0a, 5'h11};
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;

  scc_core #(.IDENTITY(IDV)) scc_core_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .exc_in, .parity_in, .debug_return_instr, .wait_instr, .wake,
    .perf_events, .tck, .tms, .tdi, .tdo, .debug_mode, .sleep_req, .idle_req,
    .parity_en, .irq);
  scc_probe probe_inst (.tck, .tms, .tdi, .tdo);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  function logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd
  task automatic fail(input string s);
    n_errors++;
    $display("MISMATCH at %0t: %s", $time, s);
  endtask : fail
  task automatic cmp_b(input logic [1:0] e);
    check_count++;
    if (s_axi_bresp !== e) fail("write response");
  endtask : cmp_b
  task automatic cmp_r(input logic [65:0] x);
    check_count++;
    if ((s_axi_rdata & x[33:2]) !== x[65:34] || s_axi_rresp !== x[1:0]) fail("read");
  endtask : cmp_r
  task automatic cmp_v(input logic g, input logic e);
    check_count++;
    if (g !== e) fail("output level");
  endtask : cmp_v
  task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) fail("link word");
  endtask : cmp_w
  task automatic summarize();
    $display("errors %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [4:0] i, input logic [31:0] d,
                    input logic [1:0] e = RESP_OKAY);
    bq.push_back(e);
    s_axi_awaddr <= {1'b0, i, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask : wr
  task automatic rd(input logic [4:0] i, input logic [31:0] d,
                    input logic [31:0] m = '1, input logic [1:0] e = RESP_OKAY);
    rq.push_back({d & m, m, e});
    s_axi_araddr <= {1'b0, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (s_axi_arvalid || s_axi_rready);
  endtask : rd
  task automatic ex(input logic a, r, g, input logic [4:0] c, input logic [31:0] p, ad);
    exc_in <= '{1'b1, a, r, g, c, p, ad};
    tick(1);
    exc_in <= '0;
    tick(1);
  endtask : ex
  task automatic par(input logic [31:0] x);
    parity_in <= '{1'b1, x};
    tick(1);
    parity_in <= '0;
    tick(2);
  endtask : par

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) cmp_b(bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) cmp_r(rq.pop_front());
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {debug_return_instr, wait_instr, wake, aresetn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, perf_events} = '0;
    s_axi_wstrb = 4'hf;
    exc_in = '0;
    parity_in = '0;
    tick(20);
    aresetn <= 1'b1;
    tick(1);
    foreach (rw_l[k]) rd(rw_l[k], 32'h0);
    rd(REG_PARITY_LOG, 32'h0);
    rd(REG_CORE_CONFIG, CONFIG_RESET);
    rd(REG_PROC_IDENTITY, IDV);
    foreach (rw_l[k]) begin
      v = rnd();
      wr(rw_l[k], v);
      rd(rw_l[k], v);
    end
    foreach (rs_l[k]) begin
      wr(rs_l[k], rnd(), RESP_SLVERR);
      rd(rs_l[k], 32'h0, '1, RESP_SLVERR);
    end
    wr(REG_USER_SCRATCH, 32'h1234abcd);
    wr(REG_HW_READ_MASK, 32'h0);
    wr(REG_HW_READ_REQ, {27'h0, HWR_USER_INDEX});
    rd(REG_HW_READ_REQ, 32'h1234abcd);
    wr(REG_STATUS_CTL, 32'h1 << STATUS_USER_BIT);
    rd(REG_HW_READ_REQ, 32'h0);
    wr(REG_HW_READ_MASK, 32'h1 << 29);
    rd(REG_HW_READ_REQ, 32'h1234abcd);
    wr(REG_STATUS_CTL, 32'h0);
    wr(REG_IRQ_ENABLE, 32'h1 << IRQ_EXC);
    ex(1'b1, 1'b0, 1'b0, 5'h04, 32'h00000100, 32'h000dead0);
    rd(REG_FAULT_ADDR, 32'h000dead0);
    rd(REG_EXC_RET_PC, 32'h00000100);
    rd(REG_EXC_REASON, 32'h04 << 2, 32'h7c);
    cmp_v(irq, 1'b1);
    wr(REG_IRQ_CLEAR, 32'h1 << IRQ_EXC);
    cmp_v(irq, 1'b0);
    wr(REG_IRQ_ENABLE, 32'h0);
    ex(1'b0, 1'b1, 1'b0, 5'h1e, 32'h00000200, 32'h0);
    rd(REG_ERR_RET_PC, 32'h00000200);
    rd(REG_EXC_RET_PC, 32'h00000100);
    rd(REG_FAULT_ADDR, 32'h000dead0);
    rd(REG_EXC_REASON, 32'h1e << 2, 32'h7c);
    rd(REG_IRQ_STATUS, 32'h1 << IRQ_EXC, 32'h1 << IRQ_EXC);
    cmp_v(irq, 1'b0);
    wr(REG_IRQ_ENABLE, 32'h1 << IRQ_DEBUG);
    ex(1'b0, 1'b0, 1'b1, 5'h09, 32'h00000300, 32'h0);
    cmp_v(debug_mode, 1'b1);
    rd(REG_DEBUG_RET_PC, 32'h00000300);
    rd(REG_EXC_RET_PC, 32'h00000100);
    cmp_v(debug_mode, 1'b1);
    cmp_v(irq, 1'b1);
    debug_return_instr <= 1'b1;
    tick(1);
    debug_return_instr <= 1'b0;
    tick(2);
    cmp_v(debug_mode, 1'b0);
    wr(REG_IRQ_ENABLE, 32'h0);
    wr(REG_PARITY_CTL, 32'h1 << PARITY_EN_BIT);
    cmp_v(parity_en, 1'b1);
    par(32'h0bad0001);
    rd(REG_PARITY_LOG, 32'h0bad0001);
    wr(REG_PARITY_CTL, 32'h0);
    cmp_v(parity_en, 1'b0);
    par(32'h0bad0002);
    rd(REG_PARITY_LOG, 32'h0bad0001);
    wr(REG_PERF, 32'h1 << PERF_EN_BIT);
    perf_events <= 2'b11;
    tick(10);
    perf_events <= 2'b00;
    tick(3);
    rd(REG_PERF_TALLY0, 32'd10);
    rd(REG_PERF_TALLY1, 32'd0);
    wr(REG_CYCLE_TALLY, 32'h0);
    wr(REG_TIMER_MATCH, 32'd200);
    wr(REG_IRQ_ENABLE, 32'h1 << IRQ_TIMER);
    cmp_v(irq, 1'b0);
    tick(250);
    cmp_v(irq, 1'b1);
    wr(REG_TIMER_MATCH, 32'd200);
    cmp_v(irq, 1'b0);
    for (int s = 0; s < 2; s++) begin
      wr(REG_STATUS_CTL, s);
      wait_instr <= 1'b1;
      tick(1);
      wait_instr <= 1'b0;
      tick(1);
      cmp_v(sleep_req, s[0]);
      cmp_v(idle_req, !s[0]);
      wake <= 1'b1;
      tick(1);
      wake <= 1'b0;
      tick(1);
      cmp_v(sleep_req | idle_req, 1'b0);
    end
    v = rnd();
    wr(REG_DEBUG_SCRATCH, 32'h5eed0517);
    probe_inst.ir(TAP_IR_DATA);
    probe_inst.dr(v);
    cmp_w(probe_inst.cap, 32'h5eed0517);
    tick(10);
    rd(REG_DEBUG_SCRATCH, v);
    probe_inst.ir(TAP_IR_IDCODE);
    probe_inst.dr(rnd());
    cmp_w(probe_inst.cap, IDV);
    tick(10);
    rd(REG_DEBUG_SCRATCH, v);
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    rd(REG_USER_SCRATCH, 32'h0);
    summarize();
  end
endmodule : test_system_control_coprocessor
